// ==== ibd_chain_model.sv ====
// Model of the first chained device, which drives the three select lines.
`timescale 1ns/1ps
`default_nettype none
module ibd_chain_model (
    // Programming state of the select outputs.
    input  wire logic       blank_in,
    input  wire logic [2:0] prog_sel_in,
    // Select lines seen by the decoder.
    output logic [2:0]      chain_sel_out
);
    // Blank outputs float, so the board pull-ups read as all ones.
    assign chain_sel_out = blank_in ? 3'h7 : prog_sel_in;
endmodule
`default_nettype wire

// ==== ibd_isp_decoder.sv ====
// Programming-chain I/O decoder and serial-line controller behind AXI4-Lite.
//
// Overview of operation
// - Port lives in the write-only range 200-207 and only answers writes.
// - Low three address bits come from chain select outputs of first device.
// - Select lines pulled up to 111, so a fresh card answers at 207.
// - Low match true only when all three address bits equal the select.
// - Hit needs both the low match and the upper decode.
// - Enable register loads data bit zero on a hit, else holds.
// - Mode register loads mode bit AND current enable on a hit, else holds.
// - Serial clock register loads bus clock bit on a hit, else holds.
// - Serial data register loads bus data bit on a hit, else holds.
// - All four outputs are D registers driving inverted pins.
//
// Software writes an I/O address (ADDR) and data, then writes CTRL bit 0 to
// issue one I/O write strobe; the strobe is one clock-wide internal cycle.
`timescale 1ns/1ps
`default_nettype none
module ibd_isp_decoder
    import ibd_pkg::*;
(
    // Clock and reset.
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    // AXI4-Lite write channels.
    input  wire logic [11:0] s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    // AXI4-Lite read channels.
    input  wire logic [11:0] s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    // Chain select lines from the first chained device (pulled up when blank).
    input  wire logic [2:0]  chain_sel_in,
    // Programming chain pins, active low (inverted register outputs).
    output logic             isp_en_n_out,
    output logic             mode_n_out,
    output logic             sdi_n_out,
    output logic             sclk_n_out
);

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic        aw_got_ff, nxt_aw_got;
    logic        w_got_ff, nxt_w_got;
    logic [11:0] aw_addr_ff, nxt_aw_addr;
    logic [31:0] w_data_ff, nxt_w_data;
    logic [3:0]  w_strb_ff, nxt_w_strb;
    logic        bvalid_ff, nxt_bvalid;
    logic [1:0]  bresp_ff, nxt_bresp;
    logic        rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0]  rresp_ff, nxt_rresp;
    logic        arready_ff, nxt_arready;
    logic        awready_ff, nxt_awready;
    logic        wready_ff, nxt_wready;

    // I/O side state.
    logic [9:0]  io_addr_ff, nxt_io_addr;
    logic [7:0]  io_data_ff, nxt_io_data;
    logic        strobe_ff, nxt_strobe;
    logic [2:0]  sel_ltch_ff, nxt_sel_ltch;
    logic        isp_en_ff, nxt_isp_en;
    logic        mode_ff, nxt_mode;
    logic        sdi_ff, nxt_sdi;
    logic        sclk_ff, nxt_sclk;
    logic        last_hit_ff, nxt_last_hit;
    logic        done_ff, nxt_done;
    logic        isp_en_n_ff, nxt_isp_en_n;
    logic        mode_n_ff, nxt_mode_n;
    logic        sdi_n_ff, nxt_sdi_n;
    logic        sclk_n_ff, nxt_sclk_n;

    logic        wr_fire;
    logic        lsb_match;
    logic        msb_match;
    logic        port_hit;

    assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    assign lsb_match = (io_addr_ff[2:0] == sel_ltch_ff);
    assign msb_match = (io_addr_ff[9:3] == IBD_WIN_BASE[9:3]);
    assign port_hit  = lsb_match && msb_match;

    always_comb begin
        nxt_aw_got   = aw_got_ff;
        nxt_w_got    = w_got_ff;
        nxt_aw_addr  = aw_addr_ff;
        nxt_w_data   = w_data_ff;
        nxt_w_strb   = w_strb_ff;
        nxt_bvalid   = bvalid_ff;
        nxt_bresp    = bresp_ff;
        nxt_rvalid   = rvalid_ff;
        nxt_rdata    = rdata_ff;
        nxt_rresp    = rresp_ff;
        nxt_io_addr  = io_addr_ff;
        nxt_io_data  = io_data_ff;
        nxt_strobe   = 1'b0;
        nxt_awready  = !aw_got_ff && !(s_axi_awvalid_in && awready_ff);
        nxt_wready   = !w_got_ff && !(s_axi_wvalid_in && wready_ff);
        nxt_arready  = !rvalid_ff && !(s_axi_arvalid_in && arready_ff);
        if (s_axi_awvalid_in && awready_ff) begin
            nxt_aw_got  = 1'b1;
            nxt_aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && wready_ff) begin
            nxt_w_got  = 1'b1;
            nxt_w_data = s_axi_wdata_in;
            nxt_w_strb = s_axi_wstrb_in;
        end
        if (wr_fire) begin
            nxt_aw_got = 1'b0;
            nxt_w_got  = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp  = IBD_RESP_OKAY;
            unique case (aw_addr_ff)
                IBD_CTRL_OFS: begin
                    if (w_strb_ff[0]) begin
                        nxt_strobe = w_data_ff[IBD_CTRL_STRB_BIT];
                    end
                end
                IBD_ADDR_OFS: begin
                    if (w_strb_ff[0]) begin
                        nxt_io_addr[7:0] = w_data_ff[7:0];
                    end
                    if (w_strb_ff[1]) begin
                        nxt_io_addr[9:8] = w_data_ff[9:8];
                    end
                    if (w_strb_ff[2]) begin
                        nxt_io_data = w_data_ff[IBD_IO_DATA_LSB +: 8];
                    end
                end
                IBD_STATUS_OFS: begin
                    nxt_bresp = IBD_RESP_OKAY;
                end
                default: begin
                    nxt_bresp = IBD_RESP_SLVERR;
                end
            endcase
        end
        if (bvalid_ff && s_axi_bready_in) begin
            nxt_bvalid = 1'b0;
        end
        if (s_axi_arvalid_in && arready_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = IBD_RESP_OKAY;
            nxt_rdata  = IBD_ZERO32;
            unique case (s_axi_araddr_in)
                IBD_CTRL_OFS: begin
                    nxt_rdata = IBD_ZERO32;
                end
                IBD_STATUS_OFS: begin
                    nxt_rdata[IBD_ST_DONE_BIT] = done_ff;
                    nxt_rdata[IBD_ST_HIT_BIT]  = last_hit_ff;
                    nxt_rdata[IBD_ST_EN_BIT]   = isp_en_ff;
                    nxt_rdata[IBD_ST_MODE_BIT] = mode_ff;
                    nxt_rdata[IBD_ST_SDI_BIT]  = sdi_ff;
                    nxt_rdata[IBD_ST_SCLK_BIT] = sclk_ff;
                    nxt_rdata[IBD_ST_SEL_LSB +: 3] = sel_ltch_ff;
                end
                IBD_ADDR_OFS: begin
                    nxt_rdata[9:0]   = io_addr_ff;
                    nxt_rdata[IBD_IO_DATA_LSB +: 8] = io_data_ff;
                end
                default: begin
                    nxt_rresp = IBD_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready_in) begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            aw_addr_ff <= IBD_CTRL_OFS;
            w_data_ff  <= IBD_ZERO32;
            w_strb_ff  <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= IBD_RESP_OKAY;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= IBD_ZERO32;
            rresp_ff   <= IBD_RESP_OKAY;
            arready_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            io_addr_ff <= IBD_ADDR_RST;
            io_data_ff <= 8'h00;
            strobe_ff  <= 1'b0;
        end else begin
            aw_got_ff  <= nxt_aw_got;
            w_got_ff   <= nxt_w_got;
            aw_addr_ff <= nxt_aw_addr;
            w_data_ff  <= nxt_w_data;
            w_strb_ff  <= nxt_w_strb;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
            arready_ff <= nxt_arready;
            awready_ff <= nxt_awready;
            wready_ff  <= nxt_wready;
            io_addr_ff <= nxt_io_addr;
            io_data_ff <= nxt_io_data;
            strobe_ff  <= nxt_strobe;
        end
    end

    // ------------------------------------------------------------------
    // Chain controller
    // ------------------------------------------------------------------
    // The select lines are latched every cycle so that a reprogrammed chain
    // moves the port address without any software action.
    always_comb begin
        nxt_sel_ltch = chain_sel_in;
        nxt_isp_en   = isp_en_ff;
        nxt_mode     = mode_ff;
        nxt_sdi      = sdi_ff;
        nxt_sclk     = sclk_ff;
        nxt_last_hit = last_hit_ff;
        nxt_done     = done_ff;
        if (strobe_ff) begin
            nxt_last_hit = port_hit;
            nxt_done     = 1'b1;
            if (port_hit) begin
                nxt_isp_en = io_data_ff[IBD_D_EN_BIT];
                nxt_mode   = io_data_ff[IBD_D_MODE_BIT] && isp_en_ff;
                nxt_sdi    = io_data_ff[IBD_D_SDI_BIT];
                nxt_sclk   = io_data_ff[IBD_D_SCLK_BIT];
            end
        end
        // The pins get flops of their own so that no gate sits between flop and pin.
        nxt_isp_en_n = !nxt_isp_en;
        nxt_mode_n   = !nxt_mode;
        nxt_sdi_n    = !nxt_sdi;
        nxt_sclk_n   = !nxt_sclk;
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sel_ltch_ff <= IBD_SEL_DEFAULT;
            isp_en_ff   <= 1'b0;
            mode_ff     <= 1'b0;
            sdi_ff      <= 1'b0;
            sclk_ff     <= 1'b0;
            last_hit_ff <= 1'b0;
            done_ff     <= 1'b0;
            isp_en_n_ff <= 1'b1;
            mode_n_ff   <= 1'b1;
            sdi_n_ff    <= 1'b1;
            sclk_n_ff   <= 1'b1;
        end else begin
            sel_ltch_ff <= nxt_sel_ltch;
            isp_en_ff   <= nxt_isp_en;
            mode_ff     <= nxt_mode;
            sdi_ff      <= nxt_sdi;
            sclk_ff     <= nxt_sclk;
            last_hit_ff <= nxt_last_hit;
            done_ff     <= nxt_done;
            isp_en_n_ff <= nxt_isp_en_n;
            mode_n_ff   <= nxt_mode_n;
            sdi_n_ff    <= nxt_sdi_n;
            sclk_n_ff   <= nxt_sclk_n;
        end
    end

    // Pins drive the inverse of the stored state.
    assign isp_en_n_out      = isp_en_n_ff;
    assign mode_n_out        = mode_n_ff;
    assign sdi_n_out         = sdi_n_ff;
    assign sclk_n_out        = sclk_n_ff;
    assign s_axi_awready_out = awready_ff;
    assign s_axi_wready_out  = wready_ff;
    assign s_axi_bvalid_out  = bvalid_ff;
    assign s_axi_bresp_out   = bresp_ff;
    assign s_axi_arready_out = arready_ff;
    assign s_axi_rvalid_out  = rvalid_ff;
    assign s_axi_rdata_out   = rdata_ff;
    assign s_axi_rresp_out   = rresp_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_hit_loads_en: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        strobe_ff && port_hit |=> isp_en_ff == $past(io_data_ff[IBD_D_EN_BIT]))
        else $error("enable did not load on hit");
    a_miss_holds: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !(strobe_ff && port_hit) |=> $stable(sclk_ff) && $stable(sdi_ff) && $stable(isp_en_ff))
        else $error("outputs changed without hit");
    a_mode_gated: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        strobe_ff && port_hit |=> mode_ff == ($past(io_data_ff[IBD_D_MODE_BIT]) && $past(isp_en_ff)))
        else $error("mode not gated by enable");
    a_sdi_loads: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        strobe_ff && port_hit |=> sdi_ff == $past(io_data_ff[IBD_D_SDI_BIT]))
        else $error("serial data did not load");
    a_lsb_match: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        strobe_ff && io_addr_ff[2:0] != $past(chain_sel_in) |=> !last_hit_ff)
        else $error("low match wrong");
    a_hit_window: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        port_hit |-> io_addr_ff[9] && io_addr_ff[8:3] == 6'h00)
        else $error("hit outside window");
    a_pin_invert: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        isp_en_n_out != isp_en_ff && mode_n_out != mode_ff && sdi_n_out != sdi_ff && sclk_n_out != sclk_ff)
        else $error("pin not inverted");
    a_status_hit: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        strobe_ff |=> last_hit_ff == $past(lsb_match && msb_match))
        else $error("hit status wrong");
    a_resp_follows: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr_fire |=> s_axi_bvalid_out)
        else $error("no write response");
    c_hit_write: cover property (@(posedge sys_clk_in) disable iff (rst_in) strobe_ff && port_hit);
    c_miss_write: cover property (@(posedge sys_clk_in) disable iff (rst_in) strobe_ff && !port_hit);
    c_mode_set: cover property (@(posedge sys_clk_in) disable iff (rst_in) $rose(mode_ff));
    c_read: cover property (@(posedge sys_clk_in) disable iff (rst_in) s_axi_rvalid_out);

endmodule
`default_nettype wire

// ==== ibd_pkg.sv ====
// Package with constants for the programming-chain bus decoder.
package ibd_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] IBD_CTRL_OFS   = 12'h000;
    localparam logic [11:0] IBD_STATUS_OFS = 12'h004;
    localparam logic [11:0] IBD_ADDR_OFS   = 12'h008;
    // Control fields.
    localparam int IBD_CTRL_STRB_BIT = 0;
    localparam int IBD_CTRL_UPD_BIT  = 1;
    // Status fields.
    localparam int IBD_ST_DONE_BIT   = 0;
    localparam int IBD_ST_HIT_BIT    = 1;
    localparam int IBD_ST_EN_BIT     = 2;
    localparam int IBD_ST_MODE_BIT   = 3;
    localparam int IBD_ST_SDI_BIT    = 4;
    localparam int IBD_ST_SCLK_BIT   = 5;
    localparam int IBD_ST_SEL_LSB    = 8;
    // I/O data-bus bit positions.
    localparam int IBD_D_EN_BIT   = 0;
    localparam int IBD_D_MODE_BIT = 1;
    localparam int IBD_D_SDI_BIT  = 2;
    localparam int IBD_D_SCLK_BIT = 3;
    // Lowest bit of the I/O data byte inside the ADDR word.
    localparam int IBD_IO_DATA_LSB = 16;
    // Reset values and bus answers.
    localparam logic [2:0]  IBD_SEL_DEFAULT = 3'h7;
    localparam logic [9:0]  IBD_ADDR_RST    = 10'h207;
    localparam logic [9:0]  IBD_WIN_BASE    = 10'h200;
    localparam logic [1:0]  IBD_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  IBD_RESP_SLVERR = 2'h2;
    localparam logic [31:0] IBD_ZERO32      = 32'h0000_0000;
endpackage

// ==== testbench.sv ====
// Self-checking bench for the programming-chain decoder.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ibd_pkg::*;
    logic        clk, rst, awv, wv, bre, arv, rre, awr, wr, bv, arr, rv, blank;
    logic        en_n, mode_n, sdi_n, sclk_n, e_en, e_mode, e_sdi, e_sclk;
    logic [11:0] awa, ara;
    logic [31:0] wd, rd, rdq;
    logic [3:0]  ws;
    logic [1:0]  br, rr, resp;
    logic [2:0]  psel, sel;
    logic [9:0]  io;
    int          n_mismatch, checks_done, seed;
    ibd_isp_decoder ibd_isp_decoder_i (.sys_clk_in(clk), .rst_in(rst), .s_axi_awaddr_in(awa),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
        .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(bre), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_rdata_out(rd), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre),
        .chain_sel_in(sel), .isp_en_n_out(en_n), .mode_n_out(mode_n), .sdi_n_out(sdi_n),
        .sclk_n_out(sclk_n));
    ibd_chain_model ibd_chain_model_i (.blank_in(blank), .prog_sel_in(psel), .chain_sel_out(sel));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------------
    // Bus tasks and checks
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic hang(input int n);
        if (n >= 100) begin
            n_mismatch++;
            $display("[ERR] handshake expected 1 seen 0");
            final_report();
        end
    endtask
    // Address and data are offered together and each is dropped once taken.
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        int n;
        logic ad, dd;
        @(posedge clk);
        awa <= a; awv <= 1'b1; wd <= d; wv <= 1'b1; ad = 1'b0; dd = 1'b0; n = 0;
        while (!(ad && dd) && n < 100) begin
            @(posedge clk);
            if (!ad && awr) begin ad = 1'b1; awv <= 1'b0; end
            if (!dd && wr) begin dd = 1'b1; wv <= 1'b0; end
            n++;
        end
        hang(n);
        bre <= 1'b1; n = 0;
        do begin @(posedge clk); n++; end while (!bv && n < 100);
        hang(n);
        resp = br; bre <= 1'b0;
    endtask
    task automatic axr(input logic [11:0] a);
        int n;
        @(posedge clk);
        ara <= a; arv <= 1'b1; n = 0;
        do begin @(posedge clk); n++; end while (!arr && n < 100);
        hang(n);
        arv <= 1'b0; rre <= 1'b1; n = 0;
        do begin @(posedge clk); n++; end while (!rv && n < 100);
        hang(n);
        rdq = rd; resp = rr; rre <= 1'b0;
    endtask
    function automatic logic hit_f(input logic [9:0] a, input logic [2:0] s);
        return a[9:3] == 7'h40 && a[2:0] == s;
    endfunction
    // One I/O write cycle, then the expected pins and status.
    task automatic io_wr(input logic [9:0] a, input logic [3:0] d);
        logic h;
        axw(IBD_ADDR_OFS, {8'h00, 4'h0, d, 6'h00, a});
        h = hit_f(a, blank ? 3'h7 : psel);
        axw(IBD_CTRL_OFS, 32'h0000_0001);
        repeat (3) @(posedge clk);
        if (h) begin
            e_mode = d[1] & e_en;
            e_en = d[0];
            e_sdi = d[2];
            e_sclk = d[3];
        end
        chk("pins", {~e_sclk, ~e_sdi, ~e_mode, ~e_en}, {sclk_n, sdi_n, mode_n, en_n});
        axr(IBD_STATUS_OFS);
        chk("hit", {31'h0, h}, {31'h0, rdq[IBD_ST_HIT_BIT]});
        chk("state", {e_sclk, e_sdi, e_mode, e_en}, rdq[5:2]);
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] r;
        seed = 32'hfc28; n_mismatch = 0; checks_done = 0;
        rst = 1'b1; awv = 1'b0; wv = 1'b0; bre = 1'b0; arv = 1'b0; rre = 1'b0; ws = 4'hf;
        awa = 12'h000; ara = 12'h000; wd = 32'h0; blank = 1'b1; psel = 3'h0;
        e_en = 1'b0; e_mode = 1'b0; e_sdi = 1'b0; e_sclk = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        chk("reset pins", 4'hf, {sclk_n, sdi_n, mode_n, en_n});
        axr(IBD_ADDR_OFS);
        chk("addr reset", {22'h0, IBD_ADDR_RST}, {22'h0, rdq[9:0]});
        axr(IBD_STATUS_OFS);
        chk("blank select", 3'h7, rdq[10:8]);
        // Lane 2 masked: the address moves, the data byte must stay put.
        ws <= 4'h3;
        axw(IBD_ADDR_OFS, 32'h00ff_0205);
        ws <= 4'hf;
        axr(IBD_ADDR_OFS);
        chk("addr lanes", 32'h0000_0205, rdq);
        $display("test reset done");
        // Fresh card: only the top address hits; neighbours outside the range miss.
        io_wr(10'h207, 4'hf);
        io_wr(10'h206, 4'h0);
        io_wr(10'h20f, 4'h0);
        io_wr(10'h007, 4'h0);
        io_wr(10'h207, 4'h2);
        // Reprogramming the chain select lines moves the port off the default address.
        blank <= 1'b0;
        psel <= 3'h3;
        io_wr(10'h207, 4'h1);
        io_wr(10'h203, 4'h1);
        io_wr(10'h203, 4'h6);
        $display("test corners done");
        repeat (60) begin
            r = $random(seed);
            blank <= r[0];
            psel <= r[3:1];
            io = r[4] ? {7'h40, r[7:5]} : r[17:8];
            io_wr(io, r[21:18]);
        end
        $display("test random done");
        axr(12'h00c);
        chk("unmapped resp", IBD_RESP_SLVERR, resp);
        chk("unmapped data", IBD_ZERO32, rdq);
        axw(12'h010, 32'hffff_ffff);
        chk("unmapped wr", IBD_RESP_SLVERR, resp);
        axw(IBD_STATUS_OFS, 32'hffff_ffff);
        chk("status wr", IBD_RESP_OKAY, resp);
        $display("test bus done");
        final_report();
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        $display("[ERR] watchdog expected done seen running");
        final_report();
    end
endmodule
`default_nettype wire
